// >>> rtl/fan_ramp_pkg.sv
// Purpose: Shared constants and types for the fan ramp and floor duty block.
// Assumes: One 250 MHz clock; byte-wide register port as the unit's serial interface presents it.
// Notes:   Register offsets, field positions, reset values and ramp timing live here.
`default_nettype none
package fan_ramp_pkg;

	localparam logic [7:0] RAMP_CTRL_ADDR    = 8'h63;
	localparam logic [7:0] FLOOR_CH1_ADDR    = 8'h64;
	localparam logic [7:0] FLOOR_CH2_ADDR    = 8'h65;
	localparam logic [7:0] FLOOR_CH3_ADDR    = 8'h66;
	localparam logic [7:0] RAMP_CTRL_RESET   = 8'h00;
	localparam logic [7:0] FLOOR_DUTY_RESET  = 8'h80;
	localparam int         RATE_CH3_LSB      = 0;
	localparam int         SMOOTH_CH3_BIT    = 3;
	localparam int         RATE_CH2_LSB      = 4;
	localparam int         SMOOTH_CH2_BIT    = 7;
	localparam int         RATE_WIDTH        = 3;
	localparam int         NUM_CH            = 3;

	// Full 0 to 255 sweep at increment 1 takes 37.5 s, so one time slot is 37.5 s / 255.
	localparam longint     SWEEP_SLOWEST_US  = 37500000;
	localparam longint     CLK_MHZ           = 250;
	localparam longint     SLOT_CYCLES       = (SWEEP_SLOWEST_US * CLK_MHZ) / 255;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [NUM_CH-1:0]   auto_mode_floor;
		logic [NUM_CH-1:0]   below_hyst;
		logic [NUM_CH-1:0]   above_start;
	} temp_state_t;

	// Duty step per slot for each ramp code.
	function automatic logic [7:0] ramp_step(input logic [2:0] code);
		case (code)
			3'h0:    ramp_step = 8'h01;
			3'h1:    ramp_step = 8'h02;
			3'h2:    ramp_step = 8'h03;
			3'h3:    ramp_step = 8'h04;
			3'h4:    ramp_step = 8'h08;
			3'h5:    ramp_step = 8'h0C;
			3'h6:    ramp_step = 8'h18;
			default: ramp_step = 8'h30;
		endcase
	endfunction

endpackage
`default_nettype wire

// >>> rtl/fan_ramp_floor.sv
// Purpose: Ramp-rate and floor-duty configuration with per-channel duty smoothing.
// Assumes: The register port and control inputs are synchronous to CLK.
// Notes:   Channel 1 never smooths here; its ramp settings belong to another register.
//
// Overview of operation
// - Bits 2:0 of the ramp control register set the largest duty step of output three.
// - Ramp codes 0 to 7 give steps of 1, 2, 3, 4, 8, 12, 24 and 48 per time slot.
// - Bit 3 turns smoothing on for output three, and when clear that output takes its goal at the next PERIOD_START.
// - Bits 6:4 set the largest duty step of output two with the same code table.
// - Bit 7 turns smoothing on for output two.
// - In automatic mode writes to the ramp register and the three floor registers are ignored.
// - Three byte registers at floor_duty_ch1 to floor_duty_ch3 hold the floor duty of outputs one to three.
// - Floor duty is linear, 0x00 off through 0xFF full speed.
// - The ramp control register resets to 0x00.
// - Below threshold minus hysteresis in automatic mode a hold bit picks 0% or the floor duty.
// - In automatic mode above the start threshold a fan runs at least at its floor duty and rises from there.
`timescale 1ns/1ps
`default_nettype none
module fan_ramp_floor
	import fan_ramp_pkg::*;
#(
	parameter longint SLOT_LEN = SLOT_CYCLES
)(
	// Clock and reset.
	input  wire logic              CLK,
	input  wire logic              RST_B,
	// Register port.
	input  wire reg_req_t          REG_REQ,
	output logic [7:0]             REG_RDATA,
	// Control loop interface.
	input  wire logic              AUTO_MODE,
	input  wire logic              PERIOD_START,
	input  wire logic [NUM_CH-1:0] BELOW_HOLD,
	input  wire temp_state_t       TEMP_STATE,
	input  wire logic [7:0]        TARGET_CH1,
	input  wire logic [7:0]        TARGET_CH2,
	input  wire logic [7:0]        TARGET_CH3,
	// Duty outputs.
	output logic [7:0]             DUTY_CH1,
	output logic [7:0]             DUTY_CH2,
	output logic [7:0]             DUTY_CH3
);

	initial begin
		if (SLOT_LEN < 1 || SLOT_LEN > 64'h00000000FFFFFFFF)
			$error("SLOT_LEN out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	logic [7:0]  ramp_ctrl_reg;
	logic [7:0]  ramp_ctrl_next;
	logic [7:0]  floor_reg [NUM_CH];
	logic [7:0]  floor_next [NUM_CH];
	logic [31:0] slot_cnt_reg;
	logic [31:0] slot_cnt_next;
	logic        slot_tick;
	logic [7:0]  duty_reg [NUM_CH];
	logic [7:0]  duty_next [NUM_CH];
	logic [7:0]  target [NUM_CH];
	logic [7:0]  goal [NUM_CH];
	logic [NUM_CH-1:0] smooth_on;
	logic [2:0]  rate_code [NUM_CH];
	logic        wr_ok;

	// Writes are dropped rather than stalled, since the host cannot be held off.
	assign wr_ok = REG_REQ.wr && !AUTO_MODE;

	always_comb begin
		ramp_ctrl_next = ramp_ctrl_reg;
		for (int i = 0; i < NUM_CH; i++)
			floor_next[i] = floor_reg[i];
		if (wr_ok) begin
			case (REG_REQ.addr)
				RAMP_CTRL_ADDR: ramp_ctrl_next = REG_REQ.wdata;
				FLOOR_CH1_ADDR: floor_next[0] = REG_REQ.wdata;
				FLOOR_CH2_ADDR: floor_next[1] = REG_REQ.wdata;
				FLOOR_CH3_ADDR: floor_next[2] = REG_REQ.wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ramp_ctrl_reg <= RAMP_CTRL_RESET;
			for (int i = 0; i < NUM_CH; i++)
				floor_reg[i] <= FLOOR_DUTY_RESET;
		end else begin
			ramp_ctrl_reg <= ramp_ctrl_next;
			for (int i = 0; i < NUM_CH; i++)
				floor_reg[i] <= floor_next[i];
		end
	end

	always_comb begin
		case (REG_REQ.addr)
			RAMP_CTRL_ADDR: REG_RDATA = ramp_ctrl_reg;
			FLOOR_CH1_ADDR: REG_RDATA = floor_reg[0];
			FLOOR_CH2_ADDR: REG_RDATA = floor_reg[1];
			FLOOR_CH3_ADDR: REG_RDATA = floor_reg[2];
			default:        REG_RDATA = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	assign slot_tick = (slot_cnt_reg == 32'(SLOT_LEN - 1));

	always_comb begin
		slot_cnt_next = slot_tick ? 32'h00000000 : slot_cnt_reg + 32'h00000001;
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			slot_cnt_reg <= 32'h00000000;
		else
			slot_cnt_reg <= slot_cnt_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	assign target[0]    = TARGET_CH1;
	assign target[1]    = TARGET_CH2;
	assign target[2]    = TARGET_CH3;
	assign smooth_on[0] = 1'b0;
	assign smooth_on[1] = ramp_ctrl_reg[SMOOTH_CH2_BIT];
	assign smooth_on[2] = ramp_ctrl_reg[SMOOTH_CH3_BIT];
	assign rate_code[0] = 3'h0;
	assign rate_code[1] = ramp_ctrl_reg[RATE_CH2_LSB +: RATE_WIDTH];
	assign rate_code[2] = ramp_ctrl_reg[RATE_CH3_LSB +: RATE_WIDTH];

	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
			logic [7:0] step;
			logic [8:0] up_sum;
			assign step   = ramp_step(rate_code[c]);
			assign up_sum = {1'b0, duty_reg[c]} + {1'b0, step};

			// The floor is a lower clamp only above the start threshold in automatic mode; duty code maps linearly to duty.
			always_comb begin
				goal[c] = target[c];
				if (AUTO_MODE) begin
					if (TEMP_STATE.below_hyst[c])
						goal[c] = BELOW_HOLD[c] ? floor_reg[c] : 8'h00;
					else if (TEMP_STATE.above_start[c] && target[c] < floor_reg[c])
						goal[c] = floor_reg[c];
				end
			end

			always_comb begin
				duty_next[c] = duty_reg[c];
				if (!smooth_on[c]) begin
					if (PERIOD_START)
						duty_next[c] = goal[c];
				end else if (slot_tick) begin
					if (goal[c] > duty_reg[c])
						duty_next[c] = (up_sum > {1'b0, goal[c]}) ? goal[c] : up_sum[7:0];
					else if (goal[c] < duty_reg[c])
						duty_next[c] = (duty_reg[c] - goal[c] < step) ? goal[c]
							: duty_reg[c] - step;
				end
			end

			always_ff @(posedge CLK or negedge RST_B) begin
				if (!RST_B)
					duty_reg[c] <= 8'h00;
				else
					duty_reg[c] <= duty_next[c];
			end
		end
	endgenerate

	assign DUTY_CH1 = duty_reg[0];
	assign DUTY_CH2 = duty_reg[1];
	assign DUTY_CH3 = duty_reg[2];

endmodule
`default_nettype wire

// >>> tb/fan_ramp_floor_monitor.sv
// Purpose: Port assertions for fan_ramp_floor.
// Assumes: One clock; a mirror of the ramp register follows accepted writes.
// Notes:   The slew bound uses the largest step, so small wrong steps pass here.
`timescale 1ns/1ps
`default_nettype none
module fan_ramp_floor_monitor
	import fan_ramp_pkg::*;
(
	// Clock and reset.
	input wire logic              CLK,
	input wire logic              RST_B,
	// Register port and control.
	input wire reg_req_t          REG_REQ,
	input wire logic [7:0]        REG_RDATA,
	input wire logic              AUTO_MODE,
	input wire logic              PERIOD_START,
	input wire logic [NUM_CH-1:0] BELOW_HOLD,
	input wire temp_state_t       TEMP_STATE,
	input wire logic [7:0]        TARGET_CH1,
	input wire logic [7:0]        TARGET_CH3,
	// Duty outputs.
	input wire logic [7:0]        DUTY_CH1,
	input wire logic [7:0]        DUTY_CH3
);
	logic [7:0] ctl_reg;
	logic [7:0] ctl_next;
	logic       hit;
	logic       wr_ok;
	assign hit = REG_REQ.addr inside {[RAMP_CTRL_ADDR:FLOOR_CH3_ADDR]};
	assign wr_ok = REG_REQ.wr && !AUTO_MODE;
	always_comb
		ctl_next = wr_ok && REG_REQ.addr == RAMP_CTRL_ADDR ? REG_REQ.wdata : ctl_reg;
	always_ff @(posedge CLK or negedge RST_B)
		ctl_reg <= !RST_B ? 8'h00 : ctl_next;
	default clocking dclk @(posedge CLK); endclocking
	default disable iff (!RST_B);
	AST_WR_TAKEN: assert property (wr_ok && hit ##1 REG_REQ.addr == $past(REG_REQ.addr)
		|-> REG_RDATA == $past(REG_REQ.wdata)) else $error("write lost");
	AST_WR_LOCKED: assert property (REG_REQ.wr && AUTO_MODE
		##1 REG_REQ.addr == $past(REG_REQ.addr) |-> $stable(REG_RDATA)) else $error("locked");
	AST_UNMAPPED: assert property (!hit |-> REG_RDATA == 8'h00) else $error("unmapped");
	AST_CTRL: assert property (REG_REQ.addr == RAMP_CTRL_ADDR |-> REG_RDATA == ctl_reg)
		else $error("ramp register");
	AST_CH3_DIRECT: assert property (PERIOD_START && !AUTO_MODE && !ctl_reg[SMOOTH_CH3_BIT]
		|=> DUTY_CH3 == $past(TARGET_CH3)) else $error("direct load");
	AST_CH3_SLEW: assert property ($past(ctl_reg[SMOOTH_CH3_BIT]) |->
		DUTY_CH3 - $past(DUTY_CH3) <= 8'h30 || $past(DUTY_CH3) - DUTY_CH3 <= 8'h30) else $error("slew");
	AST_FLOOR_OFF: assert property (AUTO_MODE && PERIOD_START && TEMP_STATE.below_hyst[0]
		&& !BELOW_HOLD[0] |=> DUTY_CH1 == 8'h00) else $error("off below");
	AST_ABOVE: assert property (AUTO_MODE && PERIOD_START && !TEMP_STATE.below_hyst[0]
		&& TEMP_STATE.above_start[0] |=> DUTY_CH1 >= $past(TARGET_CH1)) else $error("above");
endmodule
bind fan_ramp_floor fan_ramp_floor_monitor fan_ramp_floor_monitor_i (.CLK, .RST_B, .REG_REQ,
	.REG_RDATA, .AUTO_MODE, .PERIOD_START, .BELOW_HOLD, .TEMP_STATE, .TARGET_CH1, .TARGET_CH3,
	.DUTY_CH1, .DUTY_CH3);
`default_nettype wire

// >>> tb/tb_fan_ramp_floor.sv
// Purpose: Self-checking bench for fan_ramp_floor.
// Assumes: Slot of 4 cycles; inputs move 1 ns after CLK rises.
// Notes:   The short slot trades real ramp timing for a fast run.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_fan_ramp_floor;
	import fan_ramp_pkg::*;
	localparam logic [7:0] STEP [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h30};
	logic        clk = '0, rst_b = '0, auto = '0, per = '0;
	reg_req_t    req = '0;
	temp_state_t temp = '0;
	logic [2:0]  hold = '0;
	logic [7:0]  t1 = '0, t2 = '0, t3 = '0, rdata, d1, d2, d3, ex;
	logic [31:0] seed = 32'h4656;
	int          err_count = 0, checks = 0, k, n;
	fan_ramp_floor #(.SLOT_LEN(4)) fan_ramp_floor_i (.CLK(clk), .RST_B(rst_b), .REG_REQ(req),
		.REG_RDATA(rdata), .AUTO_MODE(auto), .PERIOD_START(per), .BELOW_HOLD(hold),
		.TEMP_STATE(temp), .TARGET_CH1(t1), .TARGET_CH2(t2), .TARGET_CH3(t3),
		.DUTY_CH1(d1), .DUTY_CH2(d2), .DUTY_CH3(d3));
	always #2 clk = ~clk;
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic tick(int c = 1);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		req = '{1'b1, a, d};
		tick();
		req.wr = 1'b0;
		tick();
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		req.addr = a;
		#1;
		`CHK("rdata", e, rdata)
		tick();
	endtask
	task automatic pulse();
		per = 1'b1;
		tick();
		per = 1'b0;
		tick();
	endtask
	task automatic end_of_test(int bad = 0);
		err_count += bad;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		tick(5);
		rst_b = 1'b1;
		for (k = 0; k < 5; k++)
			rd(8'(8'h63 + k), k == 0 || k == 4 ? 8'h00 : FLOOR_DUTY_RESET);
		for (k = 0; k < 6; k++) begin
			ex = k == 0 ? 8'h00 : k == 1 ? 8'h40 : k == 2 ? 8'hFF : rnd();
			wr(8'(8'h64 + k % 3), ex);
			rd(8'(8'h64 + k % 3), ex);
		end
		wr(FLOOR_CH1_ADDR, 8'h40);
		auto = 1'b1;
		wr(FLOOR_CH1_ADDR, 8'h11);
		rd(FLOOR_CH1_ADDR, 8'h40);
		wr(RAMP_CTRL_ADDR, 8'hFF);
		rd(RAMP_CTRL_ADDR, 8'h00);
		$display("register test done");
		for (k = 0; k < 4; k++) begin
			hold = {2'b00, k == 0};
			temp.below_hyst = {2'b00, k < 2};
			temp.above_start = {2'b00, k > 1};
			t1 = k == 2 ? 8'h10 : 8'hC0;
			pulse();
			`CHK("duty1", k == 1 ? 8'h00 : k == 3 ? 8'hC0 : 8'h40, d1)
		end
		auto = 1'b0;
		temp = '0;
		$display("floor test done");
		for (k = 0; k < 8; k++) begin
			wr(RAMP_CTRL_ADDR, 8'h00);
			t3 = rnd();
			pulse();
			`CHK("duty3", t3, d3)
			t3 = 8'h00;
			pulse();
			ex = rnd() | 8'h01;
			t2 = 8'hFF;
			t3 = ex;
			wr(RAMP_CTRL_ADDR, {1'b1, 3'(k), 1'b1, 3'(7 - k)});
			for (n = 0; n < 20 && d2 == 8'h00; n++)
				tick();
			if (n == 20)
				end_of_test(1);
			`CHK("duty2", STEP[k], d2)
			`CHK("duty3", ex < STEP[7 - k] ? ex : STEP[7 - k], d3)
			for (n = 0; n < 20 && d2 == STEP[k]; n++)
				tick();
			if (n == 20)
				end_of_test(1);
			`CHK("duty2", 8'(2 * STEP[k]), d2)
			`CHK("duty3", ex < 2 * STEP[7 - k] ? ex : 8'(2 * STEP[7 - k]), d3)
			t2 = 8'h00;
		end
		$display("ramp test done");
		end_of_test();
	end
endmodule
`default_nettype wire
